// File: hdl/pwmdb_pkg.sv
package pwmdb_pkg;
  // register byte addresses on the bus
  localparam logic [7:0] PWMDB_OFF_DBRC  = 8'h00; // dead_band_restart_control
  localparam logic [7:0] PWMDB_OFF_STEER = 8'h04; // pulse_steering_control
  localparam logic [7:0] PWMDB_OFF_MODE  = 8'h08; // module_control_reg
  localparam logic [7:0] PWMDB_OFF_SHDN  = 8'h0C; // shutdown_event_flag
  localparam logic [7:0] PWMDB_OFF_IRQST = 8'h10;
  localparam logic [7:0] PWMDB_OFF_IRQMK = 8'h14;
  // field layout
  localparam int PWMDB_DB_W        = 7;
  localparam int PWMDB_RESTART_BIT = 7;
  localparam int PWMDB_SYNC_BIT    = 4;
  localparam int PWMDB_FLAG_BIT    = 0;
  localparam int PWMDB_NPIN        = 4;
  localparam int PWMDB_NEVT        = 2;
  localparam int PWMDB_EVT_SHUT    = 0;
  localparam int PWMDB_EVT_RESTART = 1;
  // reset values
  localparam logic [7:0] PWMDB_DBRC_RST  = 8'h00;
  localparam logic [4:0] PWMDB_STEER_RST = 5'h01;
  localparam logic [7:0] PWMDB_MODE_RST  = 8'h00;
  // mode codes
  localparam logic [1:0] PWMDB_PWM_MODE    = 2'h3; // mode field <3:2>
  localparam logic [1:0] PWMDB_BRIDGE_SGL  = 2'h0;
  localparam logic [1:0] PWMDB_BRIDGE_HALF = 2'h2;
endpackage : pwmdb_pkg

// File: hdl/pwmdb_steer_if.sv
`timescale 1ns/10ps
interface pwmdb_steer_if;
  logic [3:0] req_en;       // steering enables as written
  logic       sync;         // 1: apply at period start
  logic       period_start; // pulse at start of a pwm period
  logic [3:0] eff_en;       // enables in force
  modport ctl (output req_en, output sync, output period_start,
               input eff_en);
  modport stg (input req_en, input sync, input period_start,
               output eff_en);
endinterface : pwmdb_steer_if

// File: hdl/pwmdb_steer.sv
`timescale 1ns/10ps
module pwmdb_steer
  import pwmdb_pkg::*;
(
  input wire logic    sys_clk,
  input wire logic    nrst,
  pwmdb_steer_if.stg  sif
);
  typedef struct packed {
    logic [3:0] eff;
  } pwmdb_steer_st_t;

  pwmdb_steer_st_t st;
  pwmdb_steer_st_t next_st;

  // sync holds new enables until a period edge so no pulse is cut
  always_comb begin
    next_st = st;
    if (!sif.sync || sif.period_start) begin
      next_st.eff = sif.req_en;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st.eff <= PWMDB_STEER_RST[3:0];
    end else begin
      st <= next_st;
    end
  end

  assign sif.eff_en = st.eff;

  property p_sync_hold;
    @(posedge sys_clk) disable iff (!nrst)
      sif.sync && !sif.period_start |=> sif.eff_en == $past(sif.eff_en);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("steering changed mid period with sync set");

  property p_sync_load;
    @(posedge sys_clk) disable iff (!nrst)
      sif.sync && sif.period_start |=> sif.eff_en == $past(sif.req_en);
  endproperty
  a_sync_load: assert property (p_sync_load)
    else $error("steering not taken at period start");

  property p_imm_load;
    @(posedge sys_clk) disable iff (!nrst)
      !sif.sync |=> sif.eff_en == $past(sif.req_en);
  endproperty
  a_imm_load: assert property (p_imm_load)
    else $error("immediate steering update missed");

  c_sync_update: cover property (@(posedge sys_clk) disable iff (!nrst)
    sif.sync && sif.period_start && sif.req_en != sif.eff_en);
endmodule : pwmdb_steer

// File: hdl/pwmdb_deadband.sv
`timescale 1ns/10ps
module pwmdb_deadband
  import pwmdb_pkg::*;
#(
  parameter int W = PWMDB_DB_W
)(
  input  wire logic         sys_clk,
  input  wire logic         nrst,
  input  wire logic         en,
  input  wire logic [W-1:0] count,
  input  wire logic         in_level,
  output logic              out_level
);
  if (W < 1 || W > 16) begin : g_chk
    $error("pwmdb_deadband: W out of range");
  end

  typedef struct packed {
    logic         prev_in;
    logic [W-1:0] cnt;
  } pwmdb_db_st_t;

  pwmdb_db_st_t st;
  pwmdb_db_st_t next_st;
  logic [W-1:0] cnt_eff;

  // count loads on the rising edge; falling edge passes at once
  always_comb begin
    next_st         = st;
    next_st.prev_in = in_level;
    cnt_eff = (in_level && !st.prev_in) ? count : st.cnt;
    if (!in_level) begin
      next_st.cnt = '0;
    end else if (cnt_eff != '0) begin
      next_st.cnt = cnt_eff - 1'b1;
    end else begin
      next_st.cnt = '0;
    end
    if (!en) begin
      out_level = in_level;
    end else begin
      // only inactive-to-active edges wait
      out_level = in_level && (cnt_eff == '0);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  property p_fall_now;
    @(posedge sys_clk) disable iff (!nrst)
      en && !in_level |-> !out_level;
  endproperty
  a_fall_now: assert property (p_fall_now)
    else $error("active-to-inactive edge was delayed");

  property p_zero_delay;
    @(posedge sys_clk) disable iff (!nrst)
      en && in_level && !st.prev_in && count == '0 |-> out_level;
  endproperty
  a_zero_delay: assert property (p_zero_delay)
    else $error("zero count still delayed the edge");

  property p_two_delay;
    @(posedge sys_clk) disable iff (!nrst)
      en && in_level && !st.prev_in && count == W'(2)
      |-> !out_level ##1 (!out_level || !in_level)
      ##1 (out_level || !in_level || !en);
  endproperty
  a_two_delay: assert property (p_two_delay)
    else $error("dead band of two cycles not exact");
endmodule : pwmdb_deadband

// File: hdl/pwmdb_top.sv
// Function
// - dead-band delay acts only in half-bridge output mode.
// - only inactive-to-active edges are delayed; falling edges pass.
// - rising edge waits exactly dead_band_count instruction cycles.
// - auto restart clears the shutdown flag once the condition goes away.
// - steering works only with mode upper bits 11 and bridge mode 00.
// - each steer enable routes pwm to its pin, else port data drives it.
// - one waveform may appear on any combination of the four pins.
// - mode low bits set polarity of all steered pins.
// - shutdown forces only steered pins; port pins stay untouched.
// - sync set applies enables at period start, else at once.
// - steering register resets to 0x01; top three bits read zero.
// - with sync set, steering changes give only whole pwm pulses.
// - shutdown flag set holds outputs in shutdown state.
//
// The register offsets and register access over Wishbone were chosen for this implementation.
`timescale 1ns/10ps
module pwmdb_top
  import pwmdb_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        pwm_in,
  input  wire logic        period_start,
  input  wire logic        shutdown_cond,
  input  wire logic [3:0]  port_data,
  output logic             pwm_out_a,
  output logic             pwm_out_b,
  output logic             pwm_out_c,
  output logic             pwm_out_d,
  output logic             irq
);
  typedef struct packed {
    logic [7:0]            dbrc;     // dead_band_restart_control
    logic [4:0]            steer;    // pulse_steering_control
    logic [7:0]            mode;     // module_control_reg
    logic                  flag;     // shutdown_event_flag
    logic                  rst_wait; // waits for next period after restart
    logic [PWMDB_NEVT-1:0] irq_st;
    logic [PWMDB_NEVT-1:0] irq_mk;
    logic                  ack;
    logic [7:0]            rdata;
    logic [3:0]            pins;
    logic                  irq;
  } pwmdb_st_t;

  pwmdb_st_t  st;
  pwmdb_st_t  next_st;
  logic       acc;
  logic       wr;
  logic       single;
  logic       half;
  logic       shut;
  logic       auto_rs;
  logic       clr_flag;
  logic       pol_ac;
  logic       pol_bd;
  logic [3:0] pol;
  logic [3:0] eff;
  logic       db_a;
  logic       db_b;
  logic [PWMDB_NEVT-1:0] evt;
  // per-pin legs meet here so only one process writes next_st
  wire logic [3:0] pin_nx;

  pwmdb_steer_if sif ();

  assign sif.req_en       = st.steer[3:0];
  assign sif.sync         = st.steer[PWMDB_SYNC_BIT];
  assign sif.period_start = period_start;
  assign eff              = sif.eff_en;

  pwmdb_steer u_steer (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .sif     (sif)
  );

  // primary and complement each get their own dead band
  pwmdb_deadband #(.W(PWMDB_DB_W)) u_db_a (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .en        (half),
    .count     (st.dbrc[PWMDB_DB_W-1:0]),
    .in_level  (pwm_in),
    .out_level (db_a)
  );

  pwmdb_deadband #(.W(PWMDB_DB_W)) u_db_b (
    .sys_clk   (sys_clk),
    .nrst      (nrst),
    .en        (half),
    .count     (st.dbrc[PWMDB_DB_W-1:0]),
    .in_level  (!pwm_in),
    .out_level (db_b)
  );

  // mode decode and pair polarity; 1 means active low
  always_comb begin
    single = st.mode[3:2] == PWMDB_PWM_MODE
             && st.mode[7:6] == PWMDB_BRIDGE_SGL;
    half   = st.mode[3:2] == PWMDB_PWM_MODE
             && st.mode[7:6] == PWMDB_BRIDGE_HALF;
    pol_ac = st.mode[1];
    pol_bd = st.mode[0];
    pol    = {pol_bd, pol_ac, pol_bd, pol_ac};
    shut   = st.flag || st.rst_wait;
    auto_rs = st.dbrc[PWMDB_RESTART_BIT];
  end

  // bus strobes: one access, one ack, then ack drops
  always_comb begin
    acc = wb_cyc_i && wb_stb_i && !st.ack;
    wr  = acc && wb_we_i && wb_sel_i[0];
    clr_flag = !shutdown_cond && (auto_rs
               || (wr && wb_adr_i == PWMDB_OFF_SHDN
                   && wb_dat_i[PWMDB_FLAG_BIT]));
  end

  always_comb begin
    next_st = st;
    next_st.ack = acc;
    // register writes
    if (wr) begin
      unique case (wb_adr_i)
        PWMDB_OFF_DBRC:  next_st.dbrc   = wb_dat_i[7:0];
        PWMDB_OFF_STEER: next_st.steer  = wb_dat_i[4:0];
        PWMDB_OFF_MODE:  next_st.mode   = wb_dat_i[7:0];
        PWMDB_OFF_IRQMK: next_st.irq_mk = wb_dat_i[PWMDB_NEVT-1:0];
        default: ;
      endcase
    end
    // condition present wins over any clear
    if (shutdown_cond) begin
      next_st.flag = 1'b1;
    end else if (clr_flag) begin
      next_st.flag = 1'b0;
    end
    // after a restart output waits for the next period edge
    if (st.flag) begin
      next_st.rst_wait = 1'b1;
    end else if (period_start) begin
      next_st.rst_wait = 1'b0;
    end
    // sticky events, write one to clear, set wins
    evt[PWMDB_EVT_SHUT]    = next_st.flag && !st.flag;
    evt[PWMDB_EVT_RESTART] = st.flag && !next_st.flag;
    if (wr && wb_adr_i == PWMDB_OFF_IRQST) begin
      next_st.irq_st = st.irq_st & ~wb_dat_i[PWMDB_NEVT-1:0];
    end
    next_st.irq_st = next_st.irq_st | evt;
    next_st.irq    = |(next_st.irq_st & next_st.irq_mk);
    // read data, unmapped reads zero
    next_st.rdata = 8'h00;
    if (acc && !wb_we_i) begin
      unique case (wb_adr_i)
        PWMDB_OFF_DBRC:  next_st.rdata = st.dbrc;
        PWMDB_OFF_STEER: next_st.rdata = {3'h0, st.steer};
        PWMDB_OFF_MODE:  next_st.rdata = st.mode;
        PWMDB_OFF_SHDN:  next_st.rdata = {7'h00, st.flag};
        PWMDB_OFF_IRQST: next_st.rdata = {6'h00, st.irq_st};
        PWMDB_OFF_IRQMK: next_st.rdata = {6'h00, st.irq_mk};
        default: ;
      endcase
    end
    // pins take the muxed legs
    next_st.pins = pin_nx;
  end

  // pin mux, one leg per pin; shutdown drives the inactive level
  for (genvar i = 0; i < PWMDB_NPIN; i++) begin : g_pin
    logic leg;
    always_comb begin
      if (single) begin
        if (!eff[i]) begin
          leg = port_data[i];
        end else if (shut) begin
          leg = pol[i];
        end else begin
          leg = pwm_in ^ pol[i];
        end
      end else if (half && i < 2) begin
        leg = shut ? pol[i]
            : ((i == 0 ? db_a : db_b) ^ pol[i]);
      end else begin
        leg = port_data[i];
      end
    end
    assign pin_nx[i] = leg;
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st          <= '0;
      st.dbrc     <= PWMDB_DBRC_RST;
      st.steer    <= PWMDB_STEER_RST;
      st.mode     <= PWMDB_MODE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wb_dat_o  = {24'h000000, st.rdata};
  assign wb_ack_o  = st.ack;
  assign pwm_out_a = st.pins[0];
  assign pwm_out_b = st.pins[1];
  assign pwm_out_c = st.pins[2];
  assign pwm_out_d = st.pins[3];
  assign irq       = st.irq;

  property p_half_cd_port;
    @(posedge sys_clk) disable iff (!nrst)
      half |=> {pwm_out_d, pwm_out_c} == $past(port_data[3:2]);
  endproperty
  a_half_cd_port: assert property (p_half_cd_port)
    else $error("half bridge touched pins c or d");

  property p_no_steer;
    @(posedge sys_clk) disable iff (!nrst)
      !single && !half |=> st.pins == $past(port_data);
  endproperty
  a_no_steer: assert property (p_no_steer)
    else $error("steering acted outside single output mode");

  property p_port_pin;
    @(posedge sys_clk) disable iff (!nrst)
      single && !eff[0] |=> pwm_out_a == $past(port_data[0]);
  endproperty
  a_port_pin: assert property (p_port_pin)
    else $error("unsteered pin a not under port control");

  property p_all_four;
    @(posedge sys_clk) disable iff (!nrst)
      single && !shut && eff == 4'hF
      |=> st.pins == ($past(pol) ^ {4{$past(pwm_in)}});
  endproperty
  a_all_four: assert property (p_all_four)
    else $error("steered pins do not carry the pwm waveform");

  property p_shut_steered;
    @(posedge sys_clk) disable iff (!nrst)
      single && shut && eff[1] && !eff[0]
      |=> pwm_out_b == $past(pol_bd)
          && pwm_out_a == $past(port_data[0]);
  endproperty
  a_shut_steered: assert property (p_shut_steered)
    else $error("shutdown hit wrong pins");

  property p_auto_restart;
    @(posedge sys_clk) disable iff (!nrst)
      st.flag && auto_rs && !shutdown_cond |=> !st.flag && shut;
  endproperty
  a_auto_restart: assert property (p_auto_restart)
    else $error("auto restart did not clear the flag");

  property p_flag_holds;
    @(posedge sys_clk) disable iff (!nrst)
      st.flag && !auto_rs && !wr |=> st.flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds)
    else $error("flag cleared without software or restart");

  property p_half_shut;
    @(posedge sys_clk) disable iff (!nrst)
      half && st.flag ##1 half |-> pwm_out_a == $past(pol_ac);
  endproperty
  a_half_shut: assert property (p_half_shut)
    else $error("half bridge pin a not in shutdown state");

  property p_reset_vals;
    @(posedge sys_clk) disable iff (!nrst)
      $rose(nrst) |-> st.steer == PWMDB_STEER_RST
                      && st.dbrc == PWMDB_DBRC_RST;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("control registers wrong after reset");

  // a live condition must always win over any clear
  property p_shut_sets;
    @(posedge sys_clk) disable iff (!nrst)
      shutdown_cond |=> st.flag;
  endproperty
  a_shut_sets: assert property (p_shut_sets)
    else $error("shutdown condition did not set the flag");

  property p_soft_clear;
    @(posedge sys_clk) disable iff (!nrst)
      !shutdown_cond && wr && wb_adr_i == PWMDB_OFF_SHDN
      && wb_dat_i[PWMDB_FLAG_BIT] |=> !st.flag;
  endproperty
  a_soft_clear: assert property (p_soft_clear)
    else $error("software clear of the flag was lost");

  // single output mode must pass edges with no dead band
  property p_db_off;
    @(posedge sys_clk) disable iff (!nrst)
      single && !shut && eff[0]
      |=> pwm_out_a == ($past(pwm_in) ^ $past(pol_ac));
  endproperty
  a_db_off: assert property (p_db_off)
    else $error("pin a delayed outside half bridge mode");

  c_steer_all: cover property (@(posedge sys_clk) disable iff (!nrst)
    single && eff == 4'hF && !shut && pwm_in);
  c_half_shut: cover property (@(posedge sys_clk) disable iff (!nrst)
    half && shutdown_cond);
  c_restart: cover property (@(posedge sys_clk) disable iff (!nrst)
    st.flag && auto_rs && !shutdown_cond);
endmodule : pwmdb_top

// File: tb/pwmdb_bridge_model.sv
`timescale 1ns/10ps
// half-bridge switch pair driven by pins a (high side) and b (low side)
module pwmdb_bridge_model (
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  input  wire logic       half_mode,
  input  wire logic [3:0] pin_dir,
  input  wire logic       pwm_out_a,
  input  wire logic       pwm_out_b,
  output logic            shoot_through
);
  logic hi_on;
  logic lo_on;
  // a pin whose driver is off is pulled down at the gate
  assign hi_on = pwm_out_a & ~pin_dir[0];
  assign lo_on = pwm_out_b & ~pin_dir[1];
  // sticky: both switches on in one cycle means no dead band
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shoot_through <= 1'b0;
    end else if (half_mode && hi_on && lo_on) begin
      shoot_through <= 1'b1;
    end
  end
endmodule : pwmdb_bridge_model

// File: tb/pwmdb_top_tb.sv
`timescale 1ns/10ps
module pwmdb_top_tb
  import pwmdb_pkg::*;
;
  logic        sys_clk = 0;
  logic        nrst = 0;
  logic        cyc = 0;
  logic        stb = 0;
  logic        we = 0;
  logic        pwm_in = 0;
  logic        pst = 0;
  logic        sdc = 0;
  logic        half = 0;
  logic [7:0]  adr = 0;
  logic [31:0] wdat = 0;
  logic [3:0]  port = 0;
  logic [3:0]  sel = 4'h1;
  wire  [31:0] rdat;
  wire         ack, a, b, c, d, irq, shoot;
  wire  [3:0]  pins = {d, c, b, a};
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cyc_n = 0;
  int          k;
  logic [7:0]  q;

  always #12.5 sys_clk = ~sys_clk;

  pwmdb_top dut_u (
    .sys_clk       (sys_clk),
    .nrst          (nrst),
    .wb_cyc_i      (cyc),
    .wb_stb_i      (stb),
    .wb_we_i       (we),
    .wb_adr_i      (adr),
    .wb_sel_i      (sel),
    .wb_dat_i      (wdat),
    .wb_dat_o      (rdat),
    .wb_ack_o      (ack),
    .pwm_in        (pwm_in),
    .period_start  (pst),
    .shutdown_cond (sdc),
    .port_data     (port),
    .pwm_out_a     (a),
    .pwm_out_b     (b),
    .pwm_out_c     (c),
    .pwm_out_d     (d),
    .irq           (irq)
  );

  pwmdb_bridge_model bridge_u (
    .sys_clk       (sys_clk),
    .nrst          (nrst),
    .half_mode     (half),
    .pin_dir       (4'h0),
    .pwm_out_a     (a),
    .pwm_out_b     (b),
    .shoot_through (shoot)
  );

  // hang guard, well above the longest run
  always @(posedge sys_clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic wb(input logic w, input logic [7:0] ad,
                    input logic [7:0] dv);
    @(posedge sys_clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= ad;
    wdat <= {24'h0, dv};
    // ack ends this wait; the hang guard stops a run whose ack never comes
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    q = rdat[7:0];
    cyc <= 0;
    stb <= 0;
  endtask : wb

  task automatic chk8(input string s, input logic [7:0] e,
                      input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk8

  task automatic chk4(input string s, input logic [3:0] e,
                      input logic [3:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s exp %h got %h", s, e, g);
    end
  endtask : chk4

  // look just after the edge so registered pins have landed
  task automatic look(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : look

  // cycles since the launching edge until pin i shows level l
  task automatic rise(input int i, input logic l);
    k = 1;
    while (pins[i] !== l && k < 300) begin
      look(1);
      k++;
    end
  endtask : rise

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  task automatic t_regs;
    wb(0, PWMDB_OFF_DBRC, 8'h00);
    chk8("dbrc reset", 8'h00, q);
    wb(0, PWMDB_OFF_STEER, 8'h00);
    chk8("steer reset", 8'h01, q);
    wb(1, PWMDB_OFF_STEER, 8'hFF);
    wb(0, PWMDB_OFF_STEER, 8'h00);
    chk8("steer top bits", 8'h1F, q);
    wb(1, PWMDB_OFF_DBRC, 8'hFF);
    wb(0, PWMDB_OFF_DBRC, 8'h00);
    chk8("dbrc rw", 8'hFF, q);
    wb(1, 8'h20, 8'hFF);
    wb(0, 8'h20, 8'h00);
    chk8("unmapped", 8'h00, q);
    wb(1, PWMDB_OFF_DBRC, 8'h00);
    // a write with byte lane 0 off must not land
    sel <= 4'h0;
    wb(1, PWMDB_OFF_DBRC, 8'h55);
    sel <= 4'h1;
    wb(0, PWMDB_OFF_DBRC, 8'h00);
    chk8("sel off write", 8'h00, q);
    wb(1, PWMDB_OFF_STEER, 8'h01);
    $display("regs test done");
  endtask : t_regs

  task automatic t_steer;
    logic [3:0] pol;
    logic [3:0] e;
    logic [3:0] x;
    logic [7:0] mds [4] = '{8'h4C, 8'hCC, 8'h08, 8'h00};
    port <= 4'hA;
    for (int p = 0; p < 4; p++) begin
      wb(1, PWMDB_OFF_MODE, 8'h0C | 8'(p));
      pol = {p[0], p[1], p[0], p[1]};
      for (int i = 0; i < 16; i++) begin
        wb(1, PWMDB_OFF_STEER, 8'(i));
        pwm_in <= i[1];
        look(3);
        e = 4'(i);
        x = (e & ({4{i[1]}} ^ pol)) | (~e & port);
        chk4("steer", x, pins);
      end
    end
    for (int j = 0; j < 4; j++) begin
      wb(1, PWMDB_OFF_MODE, mds[j]);
      look(3);
      chk4("not single", port, pins);
    end
    wb(1, PWMDB_OFF_STEER, 8'h01);
    port <= 4'h0;
    pwm_in <= 0;
    $display("steer test done");
  endtask : t_steer

  task automatic t_db(input logic [6:0] n, input logic h);
    wb(1, PWMDB_OFF_MODE, h ? 8'h8C : 8'h0C);
    wb(1, PWMDB_OFF_DBRC, {1'b0, n});
    half <= h;
    look(n + 4);
    @(posedge sys_clk);
    pwm_in <= 1;
    look(1);
    chk4("b fall", 4'h0, {3'h0, b});
    rise(0, 1'b1);
    chk8("a delay", h ? n + 8'h01 : 8'h01, 8'(k));
    @(posedge sys_clk);
    pwm_in <= 0;
    look(1);
    chk4("a fall", 4'h0, {3'h0, a});
    if (h) begin
      rise(1, 1'b1);
      chk8("b delay", n + 8'h01, 8'(k));
    end
    $display("dead band test done");
  endtask : t_db

  task automatic t_sync;
    wb(1, PWMDB_OFF_MODE, 8'h0C);
    pwm_in <= 1;
    look(3);
    chk4("sync start", 4'h1, pins);
    wb(1, PWMDB_OFF_STEER, 8'h1E);
    look(10);
    chk4("sync hold", 4'h1, pins);
    @(posedge sys_clk);
    pst <= 1;
    @(posedge sys_clk);
    pst <= 0;
    look(3);
    chk4("sync apply", 4'hE, pins);
    wb(1, PWMDB_OFF_STEER, 8'h03);
    look(3);
    chk4("sync off", 4'h3, pins);
    wb(1, PWMDB_OFF_STEER, 8'h01);
    $display("sync test done");
  endtask : t_sync

  task automatic pulse_period;
    @(posedge sys_clk);
    pst <= 1;
    @(posedge sys_clk);
    pst <= 0;
    look(3);
  endtask : pulse_period

  task automatic t_shut;
    port <= 4'hE;
    wb(1, PWMDB_OFF_IRQMK, 8'h03);
    sdc <= 1;
    look(3);
    chk4("shut pins", 4'hE, pins);
    chk4("irq on", 4'h1, {3'h0, irq});
    wb(1, PWMDB_OFF_SHDN, 8'h01);
    wb(0, PWMDB_OFF_SHDN, 8'h00);
    chk8("flag held", 8'h01, q);
    sdc <= 0;
    look(4);
    wb(0, PWMDB_OFF_SHDN, 8'h00);
    chk8("no restart", 8'h01, q);
    wb(1, PWMDB_OFF_SHDN, 8'h01);
    wb(0, PWMDB_OFF_SHDN, 8'h00);
    chk8("sw clear", 8'h00, q);
    look(2);
    chk4("wait period", 4'hE, pins);
    pulse_period();
    chk4("resumed", 4'hF, pins);
    wb(0, PWMDB_OFF_IRQST, 8'h00);
    chk8("irq status", 8'h03, q);
    wb(1, PWMDB_OFF_IRQST, 8'h03);
    look(2);
    chk4("irq clear", 4'h0, {3'h0, irq});
    wb(1, PWMDB_OFF_IRQMK, 8'h00);
    wb(1, PWMDB_OFF_DBRC, 8'h80);
    sdc <= 1;
    look(3);
    @(posedge sys_clk);
    sdc <= 0;
    look(4);
    wb(0, PWMDB_OFF_SHDN, 8'h00);
    chk8("auto restart", 8'h00, q);
    wb(0, PWMDB_OFF_IRQST, 8'h00);
    chk8("auto status", 8'h03, q);
    chk4("irq masked", 4'h0, {3'h0, irq});
    wb(1, PWMDB_OFF_IRQMK, 8'h02);
    look(2);
    chk4("irq unmask", 4'h1, {3'h0, irq});
    $display("shutdown test done");
  endtask : t_shut

  initial begin
    repeat (8) @(posedge sys_clk);
    nrst <= 1;
    @(posedge sys_clk);
    t_regs();
    t_steer();
    t_db(7'h05, 1'b1);
    t_db(7'h00, 1'b1);
    t_db(7'h7F, 1'b1);
    t_db(7'h05, 1'b0);
    chk4("shoot through", 4'h0, {3'h0, shoot});
    half <= 0;
    t_sync();
    t_shut();
    complete_run();
  end
endmodule : pwmdb_top_tb
